//--- core/scale_command_port.sv
// Top of the multidrop scale command port: print buffer and bus control.
`timescale 1ns/10ps
`include "scale_port_defs.svh"
module scale_command_port (
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // Configuration from setup.
   input  wire logic        multidrop_en_i,
   input  wire logic [6:0]  bus_addr_i,
   input  wire logic        addr_load_i,
   // Received character stream from the line receiver.
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   // Formatted print data from the weight formatter.
   input  wire logic        print_valid_i,
   input  wire logic [7:0]  print_data_i,
   // Transmit character stream to the line transmitter.
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   output logic             bus_drive_en_o,
   // Requests to the weighing core.
   output logic             print_req_o,
   output logic             zero_req_o,
   // Status.
   output logic [8:0]       buf_count_o,
   output logic [6:0]       bus_addr_o
);
   // Whole core state in one struct. The buffer sits in it as well, so a
   // reset empties the buffer and one register process holds everything.
   typedef struct packed {
      logic [255:0][7:0] mem;        // Byte slots of the print buffer.
      logic [6:0]        addr;       // Configured bus address.
      logic [7:0]        wr_ptr;     // Next write slot.
      logic [7:0]        rd_ptr;     // Oldest stored byte.
      logic [8:0]        count;      // Bytes held.
      logic              dumping;    // Dump in progress, bus owned.
      logic              tx_valid;   // Byte offered to the line transmitter.
      logic [7:0]        tx_data;    // Byte being offered.
      logic              drive_en;   // Line driver enabled.
      logic              print_req;  // One-cycle request for a new reading.
      logic              zero_req;   // One-cycle request to zero the scale.
   } core_state_t;
   core_state_t r;       // Registered state.
   core_state_t next_r;  // Value for the next edge.
   logic        buf_wr;  // Write into the buffer this cycle.

   // How a dump runs, counted from the edge that takes the carriage return:
   // that same edge makes the parser show the decoded command, the next edge
   // takes the bus, and the edge after that offers the oldest byte. Each
   // edge with the transmitter ready then offers the next byte. Once the
   // buffer is empty and the last byte has been taken, that same edge lets
   // go of the bus, and the node stays silent until the next dump.

   // The buffer is a ring of byte slots. When it is full, a new byte takes
   // the oldest slot and the read pointer moves on, so a dump returns the
   // newest bytes that fit, oldest first. A reading cut in two this way is a
   // limitation the host has to live with; dumping often avoids it.

   // A mode change counts as a setup action: leaving multidrop mode drops
   // whatever the buffer holds, and entering it releases the bus at its first edge.

   // Decoded commands travel from the parser to this core on one link.
   scale_cmd_if cmd_bus ();

   // Step a buffer pointer; the 8-bit pointer wraps at the buffer's end.
   // Both pointers use it, so the wrap rule sits in one place.
   function automatic logic [7:0] ptr_inc(input logic [7:0] p);
      ptr_inc = p + 8'h01;
   endfunction

   // Frame parser feeding decoded commands. It sees the registered address,
   // so a new address applies from the next character on. Characters are
   // only parsed in multidrop mode; a point-to-point link decodes nothing.
   scale_frame_parser u_parser (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .rx_valid_i (rx_valid_i & multidrop_en_i),
      .rx_data_i  (rx_data_i),
      .bus_addr_i (r.addr),
      .cmd_o      (cmd_bus.parser)
   );

   // Buffer writes happen only in multidrop mode; direct mode bypasses it.
   // Every print source lands here, the panel key and the print command alike.
   assign buf_wr = multidrop_en_i && print_valid_i;

   // Next-state logic for the address, the buffer and the transmitter.
   // Later blocks override earlier ones, so the direct-mode clear at the
   // end wins over any buffer update in the same cycle.
   always_comb begin
      logic pop;
      pop = 1'b0;
      next_r = r;
      // Request outputs are pulses and fall back unless set again below.
      next_r.print_req = 1'b0;
      next_r.zero_req  = 1'b0;
      // Address only changes through setup; values above 99 are refused.
      // The factory value 00 answers broadcasts only.
      if (addr_load_i && bus_addr_i <= `ADDR_MAX) begin
         next_r.addr = bus_addr_i;
      end
      // A decoded command arrives one cycle after its carriage return.
      if (cmd_bus.valid) begin
         case (cmd_bus.cmd)
            // Print asks the formatter; its bytes come back on the print input.
            scale_port_pkg::CMD_PRINT: next_r.print_req = 1'b1;
            // Zero does what the front-panel key does.
            scale_port_pkg::CMD_ZERO:  next_r.zero_req = 1'b1;
            scale_port_pkg::CMD_DUMP: begin
               // Broadcast dump is still honoured; the master must not send it.
               // A second dump while one runs changes nothing.
               if (!r.dumping) begin
                  // The bus is taken here; the first byte follows one edge later.
                  next_r.dumping = 1'b1;
                  next_r.drive_en = 1'b1;
               end
            end
            // No command: nothing to do.
            default: next_r.print_req = 1'b0;
         endcase
      end
      if (!multidrop_en_i) begin
         // Point-to-point: print data goes straight out, bus always driven.
         // A byte offered while the transmitter is busy is lost, since this
         // mode has no buffer of its own.
         next_r.dumping  = 1'b0;
         next_r.drive_en = 1'b1;
         if (!r.tx_valid || tx_ready_i) begin
            next_r.tx_valid = print_valid_i;
            next_r.tx_data  = print_data_i;
         end
      end else begin
         // Multidrop: the line belongs to the master unless a dump runs.
         // The transmitter took the offered byte.
         if (r.tx_valid && tx_ready_i) begin
            next_r.tx_valid = 1'b0;
         end
         // While dumping, offer the oldest byte as soon as the slot is free.
         if (r.dumping && (!r.tx_valid || tx_ready_i)) begin
            if (r.count != 9'h000) begin
               pop = 1'b1;
               next_r.tx_valid = 1'b1;
               next_r.tx_data  = r.mem[r.rd_ptr];
            end else begin
               // Buffer empty and last byte taken: release the bus.
               next_r.dumping  = 1'b0;
               next_r.drive_en = 1'b0;
            end
         end
         // Outside a dump the node stays off the shared line.
         if (!r.dumping && !next_r.dumping) begin
            next_r.drive_en = 1'b0;
         end
      end
      // Buffer write; a full buffer drops its oldest byte to keep the newest.
      // A write and a dump read in one cycle move both pointers together.
      if (buf_wr) begin
         next_r.mem[r.wr_ptr] = print_data_i;
         next_r.wr_ptr = ptr_inc(r.wr_ptr);
         if (r.count == `BUF_DEPTH && !pop) begin
            // Full: the oldest byte is overwritten and the count stays.
            next_r.rd_ptr = ptr_inc(r.rd_ptr);
         end else if (!pop) begin
            // Room left: one more byte is held.
            next_r.count = r.count + 9'h001;
         end else begin
            // One in, one out: the count stays.
            next_r.rd_ptr = ptr_inc(r.rd_ptr);
         end
      end else if (pop) begin
         // One out: the dump frees a slot.
         next_r.rd_ptr = ptr_inc(r.rd_ptr);
         next_r.count  = r.count - 9'h001;
      end
      // Direct mode empties the buffer, so stale readings never reach a dump.
      if (!multidrop_en_i) begin
         next_r.count  = 9'h000;
         next_r.rd_ptr = 8'h00;
         next_r.wr_ptr = 8'h00;
      end
   end

   // State register. Its reset branch loads constants only, and the
   // address returns to its factory value here.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
         r.addr <= `ADDR_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Nothing combinational reaches a pin: every output is a field of the
   // state register, which keeps the line driver enable free of glitches.
   assign tx_valid_o     = r.tx_valid;
   assign tx_data_o      = r.tx_data;
   assign bus_drive_en_o = r.drive_en;
   assign print_req_o    = r.print_req;
   assign zero_req_o     = r.zero_req;
   assign buf_count_o    = r.count;
   assign bus_addr_o     = r.addr;
endmodule

//--- core/scale_port_defs.svh
// Constants for the multidrop scale command port.
`ifndef SCALE_PORT_DEFS_SVH
`define SCALE_PORT_DEFS_SVH
`define CHAR_CR        8'h0d
`define CHAR_ZERO      8'h30
`define CHAR_NINE      8'h39
`define CMD_PRINT      8'h57
`define CMD_ZERO       8'h5a
`define CMD_DUMP       8'h44
`define ADDR_BCAST     7'h00
`define ADDR_RESET     7'h00
`define ADDR_MAX       7'h63
`define BUF_DEPTH      9'h100
`define DIGIT_TEN      7'h0a
`endif

//--- core/scale_port_pkg.sv
// Types shared by the multidrop scale command port.
package scale_port_pkg;
   typedef enum logic [2:0] {
      PS_IDLE, PS_ADDR1, PS_CMD, PS_END, PS_SKIP
   } parse_state_t;
   typedef enum logic [1:0] {
      CMD_NONE, CMD_PRINT, CMD_ZERO, CMD_DUMP
   } scale_command_field_t;
endpackage

//--- core/scale_cmd_if.sv
// Interface carrying decoded commands from the frame parser to the port core.
`timescale 1ns/10ps
interface scale_cmd_if;
   logic                                 valid;  // One-cycle command pulse.
   scale_port_pkg::scale_command_field_t cmd;    // Decoded command.
   logic                                 bcast;  // Frame was broadcast.
   modport parser (output valid, output cmd, output bcast);
   modport core   (input valid, input cmd, input bcast);
endinterface

//--- core/scale_frame_parser.sv
// Frame parser: address, command character and carriage return.
`timescale 1ns/10ps
`include "scale_port_defs.svh"
module scale_frame_parser (
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // Received characters and configuration.
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic [6:0]  bus_addr_i,
   // Decoded commands.
   scale_cmd_if.parser      cmd_o
);
   // Whole parser state in one struct.
   typedef struct packed {
      scale_port_pkg::parse_state_t         st;
      logic [6:0]                           addr;
      scale_port_pkg::scale_command_field_t cmd;
      logic                                 valid;
      scale_port_pkg::scale_command_field_t out_cmd;
      logic                                 bcast;
   } parser_state_t;
   parser_state_t r;
   parser_state_t next_r;

   // True for an ASCII decimal digit.
   function automatic logic is_digit(input logic [7:0] c);
      is_digit = (c >= `CHAR_ZERO) && (c <= `CHAR_NINE);
   endfunction

   // Next-state logic; any bad character drops the frame until CR.
   always_comb begin
      logic [6:0] full_addr;
      full_addr = 7'h00;
      next_r = r;
      next_r.valid = 1'b0;
      if (rx_valid_i) begin
         case (r.st)
            scale_port_pkg::PS_IDLE: begin
               if (is_digit(rx_data_i)) begin
                  next_r.addr = 7'((rx_data_i - `CHAR_ZERO) * `DIGIT_TEN);
                  next_r.st = scale_port_pkg::PS_ADDR1;
               end else if (rx_data_i != `CHAR_CR) begin
                  next_r.st = scale_port_pkg::PS_SKIP;
               end
            end
            scale_port_pkg::PS_ADDR1: begin
               full_addr = r.addr + 7'(rx_data_i - `CHAR_ZERO);
               if (!is_digit(rx_data_i)) begin
                  next_r.st = (rx_data_i == `CHAR_CR) ? scale_port_pkg::PS_IDLE
                                                      : scale_port_pkg::PS_SKIP;
               end else if (full_addr == `ADDR_BCAST || full_addr == bus_addr_i) begin
                  next_r.addr = full_addr;
                  next_r.st = scale_port_pkg::PS_CMD;
               end else begin
                  next_r.st = scale_port_pkg::PS_SKIP;
               end
            end
            scale_port_pkg::PS_CMD: begin
               next_r.st = scale_port_pkg::PS_END;
               case (rx_data_i)
                  `CMD_PRINT: next_r.cmd = scale_port_pkg::CMD_PRINT;
                  `CMD_ZERO:  next_r.cmd = scale_port_pkg::CMD_ZERO;
                  `CMD_DUMP:  next_r.cmd = scale_port_pkg::CMD_DUMP;
                  `CHAR_CR:   next_r.st = scale_port_pkg::PS_IDLE;
                  default:    next_r.st = scale_port_pkg::PS_SKIP;
               endcase
            end
            scale_port_pkg::PS_END: begin
               if (rx_data_i == `CHAR_CR) begin
                  next_r.valid = 1'b1;
                  next_r.out_cmd = r.cmd;
                  next_r.bcast = (r.addr == `ADDR_BCAST);
                  next_r.st = scale_port_pkg::PS_IDLE;
               end else begin
                  next_r.st = scale_port_pkg::PS_SKIP;
               end
            end
            scale_port_pkg::PS_SKIP: begin
               if (rx_data_i == `CHAR_CR) begin
                  next_r.st = scale_port_pkg::PS_IDLE;
               end
            end
            default: next_r.st = scale_port_pkg::PS_IDLE;
         endcase
      end
   end

   // State register.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cmd_o.valid = r.valid;
   assign cmd_o.cmd   = r.out_cmd;
   assign cmd_o.bcast = r.bcast;
endmodule

//--- sim/scale_command_port_chk.sv
// Checker of the scale command port, bound to its top module.
`timescale 1ns/10ps
module scale_command_port_chk (
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       multidrop_en_i,
   input wire logic [6:0] bus_addr_i,
   input wire logic       addr_load_i,
   input wire logic       rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic       print_valid_i,
   input wire logic [7:0] print_data_i,
   input wire logic       tx_ready_i,
   input wire logic       tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic       bus_drive_en_o,
   input wire logic       print_req_o,
   input wire logic       zero_req_o,
   input wire logic [8:0] buf_count_o,
   input wire logic [6:0] bus_addr_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // A frame end taken on this edge.
   wire cr = rx_valid_i && multidrop_en_i && rx_data_i == 8'h0d;
   // A byte offered to the buffer while no dump is running.
   wire fill = multidrop_en_i && print_valid_i && !bus_drive_en_o;
   property p_cnt; fill |=> buf_count_o == ($past(buf_count_o) == 9'h100 ?
      9'h100 : $past(buf_count_o) + 9'h1); endproperty
   a_cnt: assert property (p_cnt) else $error("Buffer count wrong.");
   property p_max; buf_count_o <= 9'h100; endproperty
   a_max: assert property (p_max) else $error("Buffer count too big.");
   property p_addr; addr_load_i && bus_addr_i <= 7'h63 |=> bus_addr_o == $past(bus_addr_i);
   endproperty
   a_addr: assert property (p_addr) else $error("Address not loaded.");
   property p_keep; !addr_load_i |=> $stable(bus_addr_o); endproperty
   a_keep: assert property (p_keep) else $error("Address changed.");
   property p_quiet; multidrop_en_i && !bus_drive_en_o |-> !tx_valid_o; endproperty
   a_quiet: assert property (p_quiet) else $error("Sent while off the bus.");
   property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
   a_hold: assert property (p_hold) else $error("Byte dropped.");
   property p_dir; !multidrop_en_i && print_valid_i && tx_ready_i |=>
      tx_valid_o && tx_data_o == $past(print_data_i); endproperty
   a_dir: assert property (p_dir) else $error("Direct byte lost.");
   property p_req; print_req_o || zero_req_o || multidrop_en_i && $rose(bus_drive_en_o)
      |-> $past(cr, 2); endproperty
   a_req: assert property (p_req) else $error("Action without frame.");
   // The release is decided one edge before it shows, on the count seen then.
   property p_rel; multidrop_en_i && $fell(bus_drive_en_o) |-> $past(buf_count_o) == 9'h0;
   endproperty
   a_rel: assert property (p_rel) else $error("Released with data left.");
   // Main scenarios reached.
   c_zero: cover property (zero_req_o);
   c_rel: cover property ($fell(bus_drive_en_o));
   c_full: cover property (fill && buf_count_o == 9'h100);
endmodule
bind scale_command_port scale_command_port_chk i_chk (.*);

//--- sim/scale_master_model.sv
// Model of the bus master and of the line transmitter's ready.
`timescale 1ns/10ps
module scale_master_model (
   input  wire logic       core_clk_i,
   input  wire logic       slow_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            tx_ready_o
);
   logic [1:0] ph = 2'h0;  // Slow mode takes one byte in four, to stall the sender.
   always @(posedge core_clk_i) ph <= ph + 2'h1;
   assign tx_ready_o = !slow_i || ph == 2'h3;
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
   end
   // Tens digit, units digit, command, CR; dump never goes to 00.
   task automatic send(input logic [6:0] a, input logic [7:0] c);
      logic [7:0] f [4];
      f = '{8'h30 + 8'(a / 7'h0a), 8'h30 + 8'(a % 7'h0a), c, 8'h0d};
      foreach (f[i]) begin
         @(posedge core_clk_i);
         #1 rx_valid_o = 1'b1;
         rx_data_o = f[i];
      end
      @(posedge core_clk_i);
      // An idle line must not look like the last character.
      #1 rx_valid_o = 1'b0;
      rx_data_o = ~rx_data_o;
   endtask
endmodule

//--- sim/scale_command_port_tb.sv
// Self-checking bench of the scale command port.
`timescale 1ns/10ps
module scale_command_port_tb;
   logic       core_clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       md = 1'b0;
   logic [6:0] addr = 7'h00;
   logic       load = 1'b0;
   logic       pv = 1'b0;
   logic [7:0] pd = 8'h00;
   logic       slow = 1'b0;
   logic       rxv, txr, txv, drv, preq, zreq;
   logic [7:0] rxd, txd;
   logic [8:0] cnt;
   logic [6:0] aout;
   int         n_errors = 0, checks_done = 0, n_pr = 0, n_zr = 0;
   logic [7:0] got [$];  // Bytes taken by the transmitter in multidrop mode.
   always #50 core_clk_i = ~core_clk_i;
   // Tally request pulses and collect every byte handed over in multidrop mode.
   always @(posedge core_clk_i) begin
      if (preq === 1'b1) n_pr++;
      if (zreq === 1'b1) n_zr++;
      if (txv === 1'b1 && txr === 1'b1 && md) got.push_back(txd);
   end
   scale_command_port i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .multidrop_en_i(md),
      .bus_addr_i(addr), .addr_load_i(load), .rx_valid_i(rxv), .rx_data_i(rxd),
      .print_valid_i(pv), .print_data_i(pd), .tx_ready_i(txr), .tx_valid_o(txv),
      .tx_data_o(txd), .bus_drive_en_o(drv), .print_req_o(preq), .zero_req_o(zreq),
      .buf_count_o(cnt), .bus_addr_o(aout));
   scale_master_model i_master (.core_clk_i(core_clk_i), .slow_i(slow), .rx_valid_o(rxv),
      .rx_data_o(rxd), .tx_ready_o(txr));
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] act);
      checks_done++;
      if (act !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, act);
      end
   endtask
   // Ends one step after an edge, so inputs never change on the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         pv = 1'b1;
         pd = i[7:0];
         tick(1);
      end
      pv = 1'b0;
   endtask
   task automatic t_direct();
      chk("addr after reset", 9'h0, aout);
      pd = 8'h5a;
      pv = 1'b1;
      tick(1);
      pv = 1'b0;
      chk("direct data", 9'h5a, txd);
      chk("direct valid", 9'h1, txv);
      tick(2);
   endtask
   // Loads one address through setup and lets the edge after it pass.
   task automatic load_addr(input logic [6:0] a);
      addr = a;
      load = 1'b1;
      tick(1);
      load = 1'b0;
      tick(1);
   endtask
   task automatic t_addr();
      load_addr(7'h64);
      chk("addr 100", 9'h0, aout);
      load_addr(7'h63);
      chk("addr 99", 9'h63, aout);
      load_addr(7'h05);
      md = 1'b1;
      tick(2);
      chk("idle drive", 9'h0, drv);
   endtask
   task automatic t_cmds();
      i_master.send(7'h06, 8'h57);
      i_master.send(7'h7f, 8'h57);
      i_master.send(7'h05, 8'h51);
      tick(3);
      chk("refused", 9'h0, 9'(n_pr + n_zr + drv));
      i_master.send(7'h05, 8'h57);
      tick(3);
      chk("print req", 9'h1, 9'(n_pr));
      chk("print silent", 9'h0, 9'(got.size()));
      i_master.send(7'h05, 8'h5a);
      i_master.send(7'h00, 8'h5a);
      tick(3);
      chk("zero reqs", 9'h2, 9'(n_zr));
   endtask
   task automatic t_dump();
      push(260); // One finite burst of prints, no continuous print stream.
      chk("buffered", 9'h0, 9'(got.size()));
      chk("count full", 9'h100, cnt);
      slow = 1'b1;
      i_master.send(7'h05, 8'h44);
      for (int i = 0; i < 3000 && !(drv === 1'b0 && got.size() > 0); i++) tick(1);
      chk("dumped", 9'h100, 9'(got.size()));
      chk("oldest kept", 9'h04, 9'(got[0]));
      chk("newest last", 9'h03, 9'(got[255]));
      chk("cleared", 9'h0, cnt);
      chk("released", 9'h0, drv);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      tick(20);
      rst_n_i = 1'b1;
      tick(1);
      t_direct();
      t_addr();
      t_cmds();
      t_dump();
      wrap_up();
   end
   // The tests need some 1,400 cycles; 30,000 means a hang.
   initial begin
      #3000000;
      n_errors++;
      wrap_up();
   end
endmodule
